//--- shared/flash_ctrl_pkg.sv
`default_nettype none
package flash_ctrl_pkg;
    // operating modes decoded from the control pins
    typedef enum logic [2:0] {
        MODE_SHUTDOWN = 3'b000,
        MODE_STARTUP  = 3'b001,
        MODE_TORCH    = 3'b010,
        MODE_FLASH    = 3'b011,
        MODE_TX_TORCH = 3'b100,
        MODE_TIMEOUT  = 3'b101
    } op_mode_t;

    // charge-pump gain ladder, ordered low to high
    typedef enum logic [1:0] {
        GAIN_1X   = 2'b00,
        GAIN_1P5X = 2'b01,
        GAIN_2X   = 2'b10
    } gain_t;

    // synchronised control pins
    typedef struct packed {
        logic enable;
        logic torch_flash_select;
        logic rf_transmit_hold;
        logic fourth_sink_disable;
    } ctrl_pins_t;

    // sink drive: level select and per-sink on
    typedef struct packed {
        logic       use_flash_level;
        logic [3:0] sink_on;
    } sink_drive_t;

    localparam int unsigned CLK_HZ          = 20_000_000;
    localparam int unsigned TORCH_STEP_MS   = 125;
    localparam int unsigned FLASH_STEP_MS   = 2;
    localparam int unsigned FLASH_LIMIT_MS  = 1000;
    localparam int unsigned TORCH_STEP_CYC  = TORCH_STEP_MS * (CLK_HZ / 1000);
    localparam int unsigned FLASH_STEP_CYC  = FLASH_STEP_MS * (CLK_HZ / 1000);
    localparam int unsigned FLASH_LIMIT_CYC = FLASH_LIMIT_MS * (CLK_HZ / 1000);
    localparam int unsigned SOFT_RAMP_STEPS = 16;
    localparam int unsigned SOFT_RAMP_STEP_CYC = 64;
    localparam int unsigned SYNC_STAGES     = 3;
    localparam logic [3:0]  CTRL_RESET      = 4'h0;
endpackage
`default_nettype wire

//--- design/pin_sync.sv
`default_nettype none
// three-stage synchroniser; output moves only when stages two and three agree
module pin_sync
    import flash_ctrl_pkg::*;
#(
    parameter int unsigned WIDTH = 4
) (
    // clock and reset
    input  wire logic             sys_clk_i,
    input  wire logic             rst_n_i,
    // data
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] s1_reg;
    logic [WIDTH-1:0] s2_reg;
    logic [WIDTH-1:0] s3_reg;
    logic [WIDTH-1:0] out_reg;
    logic [WIDTH-1:0] out_next;

    always_comb begin
        for (int i = 0; i < WIDTH; i++) begin
            out_next[i] = (s2_reg[i] == s3_reg[i]) ? s3_reg[i] : out_reg[i];
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s1_reg  <= '0;
            s2_reg  <= '0;
            s3_reg  <= '0;
            out_reg <= '0;
        end else begin
            s1_reg  <= async_i;
            s2_reg  <= s1_reg;
            s3_reg  <= s2_reg;
            out_reg <= out_next;
        end
    end

    assign sync_o = out_reg;
endmodule
`default_nettype wire

//--- design/flash_led_mode_gain_control.sv
`default_nettype none
module flash_led_mode_gain_control
    import flash_ctrl_pkg::*;
#(
    parameter int unsigned TORCH_STEP_CYCLES  = TORCH_STEP_CYC,
    parameter int unsigned FLASH_STEP_CYCLES  = FLASH_STEP_CYC,
    parameter int unsigned FLASH_LIMIT_CYCLES = FLASH_LIMIT_CYC,
    parameter int unsigned RAMP_STEPS         = SOFT_RAMP_STEPS,
    parameter int unsigned RAMP_STEP_CYCLES   = SOFT_RAMP_STEP_CYC
) (
    // clock and reset
    input  wire logic       sys_clk_i,
    input  wire logic       resetn_i,
    // control pins, pulled low outside when undriven
    input  wire logic       enable_i,
    input  wire logic       torch_flash_select_i,
    input  wire logic       rf_transmit_hold_i,
    input  wire logic       fourth_sink_disable_i,
    // analog feedback
    input  wire logic       regulation_low_i,
    input  wire logic       output_in_regulation_i,
    // outputs
    output logic            pump_enable_o,
    output logic [1:0]      gain_o,
    output logic [4:0]      soft_start_level_o,
    output logic            use_flash_level_o,
    output logic [3:0]      led_current_sinks_o,
    output logic            timeout_o,
    output logic [2:0]      mode_o
);
    localparam int unsigned CW = $clog2(FLASH_LIMIT_CYCLES + 1);
    localparam int unsigned RW = $clog2(RAMP_STEP_CYCLES + 1);

    // reset asserts at once but is let go only on a clock edge
    logic rst_a_reg;
    logic rst_a_next;
    logic rst_b_reg;
    logic rst_b_next;
    always_comb begin
        rst_a_next = 1'b1;
        rst_b_next = rst_a_reg;
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rst_a_reg <= 1'b0;
            rst_b_reg <= 1'b0;
        end else begin
            rst_a_reg <= rst_a_next;
            rst_b_reg <= rst_b_next;
        end
    end

    // pins cross in from outside; regulation flags from the analog side too
    logic [5:0] raw_pins;
    logic [5:0] sync_pins;
    ctrl_pins_t pins;
    logic       need_gain;
    logic       in_reg;
    assign raw_pins = {enable_i, torch_flash_select_i, rf_transmit_hold_i,
                       fourth_sink_disable_i, regulation_low_i, output_in_regulation_i};

    // synchroniser runs from the released reset copy, so every pin starts low
    pin_sync #(.WIDTH(6)) u_sync (
        .sys_clk_i (sys_clk_i),
        .rst_n_i   (rst_b_reg),
        .async_i   (raw_pins),
        .sync_o    (sync_pins)
    );
    assign pins      = ctrl_pins_t'(sync_pins[5:2]);
    assign need_gain = sync_pins[1];
    assign in_reg    = sync_pins[0];

    op_mode_t          mode_reg,   mode_next;
    gain_t             gain_reg,   gain_next;
    logic [CW-1:0]     dwell_reg,  dwell_next;
    logic [CW-1:0]     flash_reg,  flash_next;
    logic [RW-1:0]     ramp_t_reg, ramp_t_next;
    logic [4:0]        level_reg,  level_next;
    logic              trip_reg,   trip_next;
    sink_drive_t       drive_reg,  drive_next;
    logic              pump_reg,   pump_next;

    logic [CW-1:0]     step_len;
    logic              ramp_done;
    logic              flash_req;
    logic              tx_hold;

    always_comb begin
        flash_req = pins.torch_flash_select;
        tx_hold   = pins.torch_flash_select && pins.rf_transmit_hold;
        step_len  = (mode_reg == MODE_FLASH) ? CW'(FLASH_STEP_CYCLES)
                                             : CW'(TORCH_STEP_CYCLES);
        ramp_done = (level_reg == 5'(RAMP_STEPS));

        mode_next   = mode_reg;
        gain_next   = gain_reg;
        dwell_next  = dwell_reg;
        flash_next  = flash_reg;
        ramp_t_next = ramp_t_reg;
        level_next  = level_reg;
        trip_next   = trip_reg;
        pump_next   = 1'b1;

        if (!pins.enable) begin
            // everything returns to its power-on state
            mode_next   = MODE_SHUTDOWN;
            gain_next   = GAIN_1X;
            dwell_next  = '0;
            flash_next  = '0;
            ramp_t_next = '0;
            level_next  = '0;
            trip_next   = 1'b0;
            pump_next   = 1'b0;
        end else begin
            // reference ramps up in equal steps to limit inrush
            if (!ramp_done) begin
                if (ramp_t_reg == RW'(RAMP_STEP_CYCLES - 1)) begin
                    ramp_t_next = '0;
                    level_next  = level_reg + 5'h01;
                end else begin
                    ramp_t_next = ramp_t_reg + RW'(1);
                end
            end

            // flash timeout runs only on a true flash, not in tx hold
            if (flash_req && !pins.rf_transmit_hold && !trip_reg) begin
                if (flash_reg >= CW'(FLASH_LIMIT_CYCLES)) begin
                    trip_next = 1'b1;
                end else begin
                    flash_next = flash_reg + CW'(1);
                end
            end else if (!flash_req) begin
                flash_next = '0;
            end

            // upward-only ladder; dwell counted while more gain is wanted
            if (need_gain && gain_reg != GAIN_2X) begin
                if (dwell_reg + CW'(1) >= step_len) begin
                    dwell_next = '0;
                    gain_next  = (gain_reg == GAIN_1X) ? GAIN_1P5X : GAIN_2X;
                end else begin
                    dwell_next = dwell_reg + CW'(1);
                end
            end else begin
                dwell_next = '0;
            end

            if (trip_next) begin
                mode_next = MODE_TIMEOUT;
            end else if (!ramp_done ||
                         (!in_reg && mode_reg == MODE_STARTUP)) begin
                mode_next = MODE_STARTUP;
            end else if (!flash_req) begin
                mode_next = MODE_TORCH;
            end else if (tx_hold) begin
                mode_next = MODE_TX_TORCH;
            end else begin
                mode_next = MODE_FLASH;
            end
        end

        // sinks follow the next mode so they switch in step with mode_o
        drive_next.use_flash_level = (mode_next == MODE_FLASH);
        if (mode_next == MODE_TORCH || mode_next == MODE_FLASH ||
            mode_next == MODE_TX_TORCH) begin
            drive_next.sink_on = {!pins.fourth_sink_disable, 3'b111};
        end else begin
            drive_next.sink_on = 4'h0;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_reg) begin
        if (!rst_b_reg) begin
            mode_reg   <= MODE_SHUTDOWN;
            gain_reg   <= GAIN_1X;
            dwell_reg  <= '0;
            flash_reg  <= '0;
            ramp_t_reg <= '0;
            level_reg  <= '0;
            trip_reg   <= 1'b0;
            drive_reg  <= '0;
            pump_reg   <= 1'b0;
        end else begin
            mode_reg   <= mode_next;
            gain_reg   <= gain_next;
            dwell_reg  <= dwell_next;
            flash_reg  <= flash_next;
            ramp_t_reg <= ramp_t_next;
            level_reg  <= level_next;
            trip_reg   <= trip_next;
            drive_reg  <= drive_next;
            pump_reg   <= pump_next;
        end
    end

    assign pump_enable_o       = pump_reg;
    assign gain_o              = gain_reg;
    assign soft_start_level_o  = level_reg;
    assign use_flash_level_o   = drive_reg.use_flash_level;
    assign led_current_sinks_o = drive_reg.sink_on;
    assign timeout_o           = trip_reg;
    assign mode_o              = mode_reg;
endmodule
`default_nettype wire

//--- sim/ctrl_pin_source.sv
`default_nettype none
// host and rf side pin drivers; a released pin reads low through its pull-down
module ctrl_pin_source
    import flash_ctrl_pkg::*;
(
    // pin levels and output enables
    input  wire ctrl_pins_t drive_i,
    input  wire logic [3:0] oe_i,
    // pins seen by the device
    output var  ctrl_pins_t pins_o
);
    timeunit 1ns;
    timeprecision 1ns;
    assign pins_o = ctrl_pins_t'(drive_i & oe_i);
endmodule
`default_nettype wire

//--- sim/flash_props.sv
`default_nettype none
module flash_props
    import flash_ctrl_pkg::*;
#(
    parameter int unsigned RAMP_STEPS = SOFT_RAMP_STEPS
) (
    // clock and reset
    input wire logic       sys_clk_i,
    input wire logic       resetn_i,
    // control pin and feedback
    input wire logic       enable_i,
    input wire logic       regulation_low_i,
    // block outputs
    input wire logic       pump_enable_o,
    input wire logic [1:0] gain_o,
    input wire logic [4:0] soft_start_level_o,
    input wire logic       use_flash_level_o,
    input wire logic [3:0] led_current_sinks_o,
    input wire logic       timeout_o,
    input wire logic [2:0] mode_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!resetn_i);
    a_enable_drop: assert property ($fell(enable_i) |-> ##[1:9] mode_o == MODE_SHUTDOWN)
        else $error("shutdown missing after enable low");
    a_off_in_shutdown: assert property (mode_o == MODE_SHUTDOWN |->
        !pump_enable_o && led_current_sinks_o == 4'h0 && gain_o == GAIN_1X)
        else $error("activity in shutdown");
    a_sinks_gated: assert property (led_current_sinks_o != 4'h0 |->
        mode_o inside {MODE_TORCH, MODE_FLASH, MODE_TX_TORCH})
        else $error("sinks on outside a run mode");
    a_sink_three_kept: assert property (led_current_sinks_o != 4'h0 |->
        led_current_sinks_o[2:0] == 3'h7)
        else $error("sinks one to three not all on");
    a_flash_level: assert property (use_flash_level_o |-> mode_o == MODE_FLASH)
        else $error("flash level outside flash mode");
    a_ramp_done: assert property (led_current_sinks_o != 4'h0 |->
        soft_start_level_o == 5'(RAMP_STEPS))
        else $error("sinks on before ramp end");
    a_gain_upward: assert property (gain_o != $past(gain_o) |->
        gain_o == $past(gain_o) + 2'h1 || mode_o == MODE_SHUTDOWN)
        else $error("gain moved other than one step up");
    a_step_cause: assert property (gain_o != $past(gain_o) && gain_o != GAIN_1X |->
        $past(regulation_low_i, 20))
        else $error("gain step without demand dwell");
    a_timeout_off: assert property (timeout_o |->
        led_current_sinks_o == 4'h0 && mode_o == MODE_TIMEOUT)
        else $error("sinks on during timeout");
    c_flash: cover property (mode_o == MODE_FLASH);
    c_gain_top: cover property (gain_o == GAIN_2X);
    c_timeout: cover property (timeout_o);
endmodule
bind flash_led_mode_gain_control flash_props #(.RAMP_STEPS(RAMP_STEPS)) flash_props_i (
    .sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .enable_i(enable_i),
    .regulation_low_i(regulation_low_i), .pump_enable_o(pump_enable_o), .gain_o(gain_o),
    .soft_start_level_o(soft_start_level_o), .use_flash_level_o(use_flash_level_o),
    .led_current_sinks_o(led_current_sinks_o), .timeout_o(timeout_o), .mode_o(mode_o));
`default_nettype wire

//--- sim/test_flash_led_mode_gain_control.sv
`default_nettype none
module test_flash_led_mode_gain_control;
    import flash_ctrl_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic       clk, rstn, reg_low, in_reg, pump, fl, tmo;
    logic [3:0] oe, sinks;
    logic [1:0] gain;
    logic [4:0] lvl;
    logic [2:0] mode;
    ctrl_pins_t drv, pins;
    int         err_total, compares, cyc;
    // each row: pins {enable, select, transmit, disable}, then {mode, sinks, flash level}
    logic [11:0] rows [7] = '{12'h85E, 12'h94E, 12'hA5E, 12'hC7F, 12'hD6F, 12'hE9E, 12'hF8E};
    wire  [7:0] st  = {mode, sinks, fl};
    wire  [7:0] aux = {4'h0, gain, tmo, pump};
    ctrl_pin_source ctrl_pin_source_i (.drive_i(drv), .oe_i(oe), .pins_o(pins));
    // shortened counts keep the run brief
    flash_led_mode_gain_control #(.TORCH_STEP_CYCLES(50), .FLASH_STEP_CYCLES(20),
        .FLASH_LIMIT_CYCLES(200), .RAMP_STEP_CYCLES(4)) flash_led_mode_gain_control_i (
        .sys_clk_i(clk), .resetn_i(rstn), .enable_i(pins.enable),
        .torch_flash_select_i(pins.torch_flash_select), .rf_transmit_hold_i(pins.rf_transmit_hold),
        .fourth_sink_disable_i(pins.fourth_sink_disable), .regulation_low_i(reg_low),
        .output_in_regulation_i(in_reg), .pump_enable_o(pump), .gain_o(gain),
        .soft_start_level_o(lvl), .use_flash_level_o(fl), .led_current_sinks_o(sinks),
        .timeout_o(tmo), .mode_o(mode));
    task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
        compares++;
        if (s !== e) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic go(input logic [3:0] p, input int n);
        drv = ctrl_pins_t'(p);
        repeat (n) @(negedge clk);
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            err_total++;
            final_report();
        end
    end
    initial begin
        drv = 4'h0;
        oe = 4'hF;
        reg_low = 1'b0;
        in_reg = 1'b0;
        rstn = 1'b0;
        repeat (3) @(negedge clk);
        chk("reset", st, 8'h00);
        rstn = 1'b1;
        go(4'h8, 100);
        chk("startup", st, 8'h20);
        chk("ramp", 8'(lvl), 8'h10);
        in_reg = 1'b1;
        foreach (rows[i]) begin
            go(rows[i][11:8], 12);
            chk("mode row", st, rows[i][7:0]);
        end
        go(4'h8, 5);
        reg_low = 1'b1;
        go(4'h8, 40);
        chk("torch dwell", aux, 8'h01);
        go(4'h8, 30);
        chk("torch step", aux, 8'h05);
        reg_low = 1'b0;
        go(4'h8, 20);
        chk("gain hold", aux, 8'h05);
        reg_low = 1'b1;
        go(4'hC, 35);
        chk("flash step", aux, 8'h09);
        go(4'hC, 30);
        chk("gain top", aux, 8'h09);
        reg_low = 1'b0;
        // a timer that kept counting during transmit would already have tripped
        go(4'hE, 150);
        go(4'hC, 30);
        chk("tx pause", aux, 8'h09);
        go(4'hC, 140);
        chk("timeout", st, 8'hA0);
        go(4'h8, 20);
        chk("sticky", aux, 8'h0B);
        oe = 4'h0;
        go(4'hF, 12);
        chk("undriven", st, 8'h00);
        chk("cleared", aux, 8'h00);
        oe = 4'hF;
        go(4'h8, 100);
        chk("restart", st, 8'h5E);
        chk("low gain", aux, 8'h01);
        final_report();
    end
endmodule
`default_nettype wire
